// ### core/lpo_panel_out.sv
/*
  LCD panel output stage: panel timing pins, panel data, CRT syncs,
  power controls with strapped polarity and memory lane A drive control.
  Assumes configuration is quasi-static on CLK and that the pixel stream,
  line and frame markers arrive synchronous to PCLK.
*/
// Contract
// - Frame start pulse high, sampled at line latch fall, marks first row.
// - Each line latch pulse falling edge latches one complete row.
// - Panel data changes on rising edge of the pixel shift clock.
// - A second shift clock output serves dual-clock color passive panels.
// - Panel data lines held low while the LCD output is disabled.
// - Eight-bit passive panels get upper nibbles of both pixel inputs forced low before pin mapping; TFT ignores the eight-bit bit.
// - TFT panels get two low blue bits on extra pins; passive alternate mapping puts lower bits 3:2 there; else low.
// - Bias power active level equals strap bit 3 at reset release.
// - Backlight power active level equals strap bit 1 at reset release.
// - Panel logic power active level equals strap bit 2 at reset release.
// - Backplane output toggles at programmed rate, or carries display enable for TFT.
// - CRT-only horizontal sync polarity follows misc output bit 6.
// - CRT-only vertical sync polarity follows the vertical polarity bit 7.
// - TFT, or CRT double scan outside passive LCD mode, drives both syncs active low.
// - Passive LCD mode holds both CRT sync outputs low.
// - Reset clears internal state, drives panel, sync and power outputs low and turns lane A drivers off.
// - All sixteen lane A lines are captured as straps at reset release.
// - Lane A drivers are off during reset or while memory clock stopped.
// - Alternate pin mapping bit selects alternate panel signal routing for passive panels; TFT ignores it.
`timescale 1ns/1ns
module lpo_panel_out (
  // Core clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Pixel link clock
  input wire logic PCLK,
  // Memory data lane A and its drive control
  input wire logic [lpo_pkg::LPO_MD_W-1:0] MEMORY_DATA_LANE_A_IN,
  output logic [lpo_pkg::LPO_MD_W-1:0] MEMORY_DATA_LANE_A_OUT,
  output logic [lpo_pkg::LPO_MD_W-1:0] MEMORY_DATA_LANE_A_OE_N,
  input wire logic MEMORY_CLOCK_STOPPED,
  input wire logic [lpo_pkg::LPO_MD_W-1:0] MEM_WR_DATA,
  input wire logic MEM_WR_EN,
  output logic [lpo_pkg::LPO_MD_W-1:0] STRAPS,
  // Configuration, core clock domain
  input wire logic LCD_ENABLE,
  input wire logic CRT_ENABLE,
  input wire lpo_pkg::lpo_panel_t PANEL_TYPE,
  input wire logic PANEL_8BIT,
  input wire logic DOUBLE_SCAN,
  input wire logic ALT_PIN_MAP,
  input wire logic TWO_SHIFT_CLOCKS,
  input wire logic HSYNC_POL_SEL,
  input wire logic VSYNC_POL_SEL,
  input wire logic [lpo_pkg::LPO_RATE_W-1:0] BACKPLANE_RATE,
  // Power requests, core clock domain
  input wire logic BIAS_ON,
  input wire logic BACKLIGHT_ON,
  input wire logic LOGIC_ON,
  // Pixel stream, pixel clock domain
  input wire logic PIX_VALID,
  input wire logic [lpo_pkg::LPO_PD_W-1:0] PIX_UPPER,
  input wire logic [lpo_pkg::LPO_PD_W-1:0] PIX_LOWER,
  input wire logic [1:0] PIX_BLUE_LOW,
  input wire logic LINE_END,
  input wire logic FRAME_FIRST,
  input wire logic HSYNC_IN,
  input wire logic VSYNC_IN,
  input wire logic DE_IN,
  // Panel pins
  output logic FRAME_START_PULSE,
  output logic LINE_LATCH_PULSE,
  output logic PIXEL_SHIFT_CLOCK,
  output logic SECOND_SHIFT_CLOCK,
  output logic [lpo_pkg::LPO_PD_W-1:0] UPPER_PANEL_DATA,
  output logic [lpo_pkg::LPO_PD_W-1:0] LOWER_PANEL_DATA,
  output logic [1:0] TFT_BLUE_LOW_BITS,
  output logic BACKPLANE_TOGGLE,
  // Panel power controls
  output logic PANEL_BIAS_POWER_CTL,
  output logic BACKLIGHT_POWER_CTL,
  output logic PANEL_LOGIC_POWER_CTL,
  // CRT syncs
  output logic HSYNC_OUT,
  output logic VSYNC_OUT
);
  import lpo_pkg::*;

  localparam int CFG_W = 10 + LPO_RATE_W;

  // Core clock domain.
  logic [LPO_MD_W:0] mem_sync;
  lpo_strap_st_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [LPO_MD_W-1:0] straps_q, straps_d;
  logic bias_q, bias_d, back_q, back_d, logic_q, logic_d;
  logic [LPO_MD_W-1:0] mda_q, mda_d, oe_n_q, oe_n_d;

  lpo_sync #(.W(LPO_MD_W + 1)) u_mem_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .din({MEMORY_CLOCK_STOPPED, MEMORY_DATA_LANE_A_IN}),
    .dout(mem_sync)
  );

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    straps_d = straps_q;
    unique case (st_q)
      LPO_ST_SETTLE: begin
        if (cnt_q == LPO_STRAP_SETTLE) begin
          straps_d = mem_sync[LPO_MD_W-1:0];
          st_d = LPO_ST_HELD;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      LPO_ST_HELD: begin
      end
    endcase
  end

  always_comb begin
    bias_d = 1'b0;
    back_d = 1'b0;
    logic_d = 1'b0;
    if (st_q == LPO_ST_HELD) begin
      bias_d = BIAS_ON ? straps_q[LPO_STRAP_BIAS] : ~straps_q[LPO_STRAP_BIAS];
      back_d = BACKLIGHT_ON ? straps_q[LPO_STRAP_BACK] : ~straps_q[LPO_STRAP_BACK];
      logic_d = LOGIC_ON ? straps_q[LPO_STRAP_LOGIC] : ~straps_q[LPO_STRAP_LOGIC];
    end
  end

  // Drivers stay off until straps are held, so the strap resistors decide them.
  always_comb begin
    mda_d = MEM_WR_DATA;
    if (st_q != LPO_ST_HELD || mem_sync[LPO_MD_W] || !MEM_WR_EN) begin
      oe_n_d = LPO_MD_ONES;
    end else begin
      oe_n_d = LPO_MD_ZERO;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= LPO_ST_SETTLE;
      cnt_q <= 3'h0;
      straps_q <= LPO_MD_ZERO;
      bias_q <= 1'b0;
      back_q <= 1'b0;
      logic_q <= 1'b0;
      mda_q <= LPO_MD_ZERO;
      oe_n_q <= LPO_MD_ONES;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      straps_q <= straps_d;
      bias_q <= bias_d;
      back_q <= back_d;
      logic_q <= logic_d;
      mda_q <= mda_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign STRAPS = straps_q;
  assign PANEL_BIAS_POWER_CTL = bias_q;
  assign BACKLIGHT_POWER_CTL = back_q;
  assign PANEL_LOGIC_POWER_CTL = logic_q;
  assign MEMORY_DATA_LANE_A_OUT = mda_q;
  assign MEMORY_DATA_LANE_A_OE_N = oe_n_q;

  // Pixel clock domain: reset asserts at once, releases on PCLK.
  logic prst1_q, prst_n_q;

  always_ff @(posedge PCLK or negedge RST_N) begin
    if (!RST_N) begin
      prst1_q <= 1'b0;
      prst_n_q <= 1'b0;
    end else begin
      prst1_q <= 1'b1;
      prst_n_q <= prst1_q;
    end
  end

  logic [CFG_W-1:0] cfg;
  logic c_lcd, c_crt, c_8b, c_dscan, c_alt, c_two, c_hpol, c_vpol;
  logic [1:0] c_type;
  logic [LPO_RATE_W-1:0] c_rate;

  lpo_sync #(.W(CFG_W)) u_cfg_sync (
    .clk(PCLK),
    .rst_n(prst_n_q),
    .din({LCD_ENABLE, CRT_ENABLE, PANEL_TYPE, PANEL_8BIT, DOUBLE_SCAN, ALT_PIN_MAP,
          TWO_SHIFT_CLOCKS, HSYNC_POL_SEL, VSYNC_POL_SEL, BACKPLANE_RATE}),
    .dout(cfg)
  );

  assign {c_lcd, c_crt, c_type, c_8b, c_dscan, c_alt, c_two, c_hpol, c_vpol, c_rate} = cfg;

  logic tft, passive;
  logic sh_q, sh_d, sh2_q, sh2_d, yd_q, yd_d, lp_q, lp_d, wf_q, wf_d;
  logic hs_q, hs_d, vs_q, vs_d;
  logic [3:0] lp_cnt_q, lp_cnt_d;
  logic [LPO_RATE_W-1:0] wf_cnt_q, wf_cnt_d;
  logic [LPO_PD_W-1:0] up_q, up_d, lo_q, lo_d, u, l;
  logic [1:0] tb_q, tb_d, b;

  assign tft = c_lcd && (lpo_panel_t'(c_type) == LPO_PANEL_TFT);
  assign passive = c_lcd && !tft;

  // Panel data formation and shift clocks.
  always_comb begin
    u = PIX_UPPER;
    l = PIX_LOWER;
    if (c_8b && !tft) begin
      u[LPO_PD_W-1:LPO_NIB] = '0;
      l[LPO_PD_W-1:LPO_NIB] = '0;
    end
    b = tft ? PIX_BLUE_LOW : 2'h0;
    up_d = up_q;
    lo_d = lo_q;
    tb_d = tb_q;
    sh_d = 1'b0;
    if (!c_lcd) begin
      up_d = LPO_PD_ZERO;
      lo_d = LPO_PD_ZERO;
      tb_d = 2'h0;
    end else if (sh_q) begin
      sh_d = 1'b0;
    end else if (PIX_VALID) begin
      sh_d = 1'b1;
      if (c_alt && passive) begin
        up_d = {l[7:4], l[1], l[0], u[7], u[6]};
        lo_d = {u[1], u[0], 2'h0, u[5], u[4], u[3], u[2]};
        tb_d = {l[3], l[2]};
      end else begin
        up_d = u;
        lo_d = l;
        tb_d = b;
      end
    end
    sh2_d = (tft || c_two) ? sh_d : 1'b0;
  end

  // Line, frame and backplane timing.
  always_comb begin
    yd_d = 1'b0;
    lp_d = 1'b0;
    wf_d = 1'b0;
    lp_cnt_d = 4'h0;
    wf_cnt_d = wf_cnt_q;
    if (tft) begin
      wf_d = DE_IN;
      lp_d = HSYNC_IN;
      yd_d = VSYNC_IN;
    end else if (passive) begin
      yd_d = yd_q;
      wf_d = wf_q;
      lp_cnt_d = (lp_cnt_q != 4'h0) ? lp_cnt_q - 4'h1 : 4'h0;
      if (LINE_END) begin
        lp_cnt_d = LPO_LP_WIDTH;
        yd_d = FRAME_FIRST;
        if (wf_cnt_q >= c_rate) begin
          wf_cnt_d = '0;
          wf_d = ~wf_q;
        end else begin
          wf_cnt_d = wf_cnt_q + 1'b1;
        end
      end
      lp_d = (lp_cnt_d != 4'h0);
    end
  end

  // CRT sync outputs.
  always_comb begin
    hs_d = 1'b0;
    vs_d = 1'b0;
    if (passive) begin
      hs_d = 1'b0;
      vs_d = 1'b0;
    end else if (tft || (c_crt && c_dscan)) begin
      hs_d = ~HSYNC_IN;
      vs_d = ~VSYNC_IN;
    end else if (c_crt) begin
      hs_d = HSYNC_IN ^ c_hpol;
      vs_d = VSYNC_IN ^ c_vpol;
    end
  end

  always_ff @(posedge PCLK or negedge prst_n_q) begin
    if (!prst_n_q) begin
      sh_q <= 1'b0;
      sh2_q <= 1'b0;
      up_q <= LPO_PD_ZERO;
      lo_q <= LPO_PD_ZERO;
      tb_q <= 2'h0;
      yd_q <= 1'b0;
      lp_q <= 1'b0;
      lp_cnt_q <= 4'h0;
      wf_q <= 1'b0;
      wf_cnt_q <= '0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      sh2_q <= sh2_d;
      up_q <= up_d;
      lo_q <= lo_d;
      tb_q <= tb_d;
      yd_q <= yd_d;
      lp_q <= lp_d;
      lp_cnt_q <= lp_cnt_d;
      wf_q <= wf_d;
      wf_cnt_q <= wf_cnt_d;
      hs_q <= hs_d;
      vs_q <= vs_d;
    end
  end

  assign PIXEL_SHIFT_CLOCK = sh_q;
  assign SECOND_SHIFT_CLOCK = sh2_q;
  assign UPPER_PANEL_DATA = up_q;
  assign LOWER_PANEL_DATA = lo_q;
  assign TFT_BLUE_LOW_BITS = tb_q;
  assign FRAME_START_PULSE = yd_q;
  assign LINE_LATCH_PULSE = lp_q;
  assign BACKPLANE_TOGGLE = wf_q;
  assign HSYNC_OUT = hs_q;
  assign VSYNC_OUT = vs_q;

endmodule

// ### core/lpo_pkg.sv
/*
  Shared constants and types for the LCD panel output stage.
  Assumes a pixel-domain timing generator and a core-clock configuration source.
*/
package lpo_pkg;

  // Panel families selected by configuration.
  typedef enum logic [1:0] {
    LPO_PANEL_MONO,
    LPO_PANEL_COLOR,
    LPO_PANEL_TFT
  } lpo_panel_t;

  // Strap capture sequence after reset release.
  typedef enum logic {
    LPO_ST_SETTLE,
    LPO_ST_HELD
  } lpo_strap_st_t;

  localparam int LPO_MD_W = 16;
  localparam int LPO_PD_W = 8;
  localparam int LPO_NIB = 4;
  localparam int LPO_RATE_W = 8;

  // Strap bit positions for the power control polarities.
  localparam int LPO_STRAP_BACK = 1;
  localparam int LPO_STRAP_LOGIC = 2;
  localparam int LPO_STRAP_BIAS = 3;

  // Synchroniser latency plus margin before straps are trusted.
  localparam logic [2:0] LPO_STRAP_SETTLE = 3'h4;

  // Width of the line latch pulse in pixel clocks.
  localparam logic [3:0] LPO_LP_WIDTH = 4'h2;

  localparam logic [LPO_PD_W-1:0] LPO_PD_ZERO = 8'h00;
  localparam logic [LPO_MD_W-1:0] LPO_MD_ZERO = 16'h0000;
  localparam logic [LPO_MD_W-1:0] LPO_MD_ONES = 16'hffff;

endpackage

// ### core/lpo_sync.sv
/*
  Three-stage synchroniser with agreement filter, one per bit.
  Assumes quasi-static levels; bits of a vector may settle a cycle apart.
*/
`timescale 1ns/1ns
module lpo_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // A bit only moves once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule

// ### sim/lpo_panel_model.sv
/*
  Panel column and row driver model that counts shift and latch events.
  Assumes it only listens to the panel pins.
*/
`timescale 1ns/1ns
module lpo_panel_model (
  // Panel pins
  input wire logic xs,
  input wire logic xs2,
  input wire logic lp,
  input wire logic yd,
  // Event counts
  output int shifts,
  output int shifts2,
  output int rows,
  output int frames
);
  // Each counter waits for a whole pulse, so the unknown-to-low step at reset never counts.
  // Data shifts in on fall.
  initial begin
    shifts = 0;
    forever begin
      @(posedge xs);
      @(negedge xs);
      shifts++;
    end
  end
  initial begin
    shifts2 = 0;
    forever begin
      @(posedge xs2);
      @(negedge xs2);
      shifts2++;
    end
  end
  initial begin
    rows = 0;
    frames = 0;
    forever begin
      @(posedge lp);
      @(negedge lp);
      rows++;
      if (yd) frames++;
    end
  end
endmodule

// ### sim/lpo_panel_out_chk.sv
/*
  Port checks for the LCD panel output stage.
  Assumes it is bound into lpo_panel_out and sees its port names.
*/
`timescale 1ns/1ns
module lpo_panel_out_chk (
  // Clocks and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PCLK,
  // Lane A, straps and power
  input wire logic MEMORY_CLOCK_STOPPED,
  input wire logic BIAS_ON,
  input wire logic PANEL_BIAS_POWER_CTL,
  input wire logic [lpo_pkg::LPO_MD_W-1:0] MEMORY_DATA_LANE_A_OE_N,
  input wire logic [lpo_pkg::LPO_MD_W-1:0] STRAPS,
  // Configuration
  input wire logic LCD_ENABLE,
  input wire logic CRT_ENABLE,
  input wire logic DOUBLE_SCAN,
  input wire logic HSYNC_POL_SEL,
  input wire logic VSYNC_POL_SEL,
  input wire lpo_pkg::lpo_panel_t PANEL_TYPE,
  // Pixel side and panel pins
  input wire logic LINE_END,
  input wire logic HSYNC_IN,
  input wire logic VSYNC_IN,
  input wire logic HSYNC_OUT,
  input wire logic VSYNC_OUT,
  input wire logic PIXEL_SHIFT_CLOCK,
  input wire logic LINE_LATCH_PULSE,
  input wire logic [lpo_pkg::LPO_PD_W-1:0] UPPER_PANEL_DATA,
  input wire logic [lpo_pkg::LPO_PD_W-1:0] LOWER_PANEL_DATA,
  input wire logic [1:0] TFT_BLUE_LOW_BITS
);
  import lpo_pkg::*;
  sequence lp_fall;
    LINE_LATCH_PULSE [*2] ##1 !LINE_LATCH_PULSE;
  endsequence
  // Eight samples cover the configuration crossing into the pixel domain.
  sequence passive_on;
    (LCD_ENABLE && PANEL_TYPE != LPO_PANEL_TFT) [*8];
  endsequence
  latch_pulse_a: assert property (@(posedge PCLK) disable iff (!RST_N)
    passive_on ##0 LINE_END |=> lp_fall) else $error("latch pulse shape wrong");
  data_rise_a: assert property (@(posedge PCLK) disable iff (!RST_N)
    LCD_ENABLE && $past(LCD_ENABLE) && $changed(UPPER_PANEL_DATA) |->
    $rose(PIXEL_SHIFT_CLOCK)) else $error("data moved without shift clock rise");
  lcd_off_a: assert property (@(posedge PCLK) disable iff (!RST_N)
    (!LCD_ENABLE) [*8] |-> UPPER_PANEL_DATA == LPO_PD_ZERO &&
    LOWER_PANEL_DATA == LPO_PD_ZERO && TFT_BLUE_LOW_BITS == 2'h0)
    else $error("panel data not low while disabled");
  bias_pol_a: assert property (@(posedge CLK) disable iff (!RST_N)
    STRAPS != LPO_MD_ZERO && $stable(STRAPS) |=>
    PANEL_BIAS_POWER_CTL == ($past(BIAS_ON) ~^ STRAPS[LPO_STRAP_BIAS]))
    else $error("bias power level wrong");
  straps_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    STRAPS != LPO_MD_ZERO |=> $stable(STRAPS)) else $error("straps changed");
  lane_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    MEMORY_CLOCK_STOPPED [*7] |-> MEMORY_DATA_LANE_A_OE_N == LPO_MD_ONES)
    else $error("lane driven while clock stopped");
  sync_low_a: assert property (@(posedge PCLK) disable iff (!RST_N)
    passive_on |-> !HSYNC_OUT && !VSYNC_OUT) else $error("sync high in lcd mode");
  tft_sync_a: assert property (@(posedge PCLK) disable iff (!RST_N)
    ((LCD_ENABLE && PANEL_TYPE == LPO_PANEL_TFT) ||
     (CRT_ENABLE && DOUBLE_SCAN && !LCD_ENABLE)) [*8] |->
    HSYNC_OUT == !$past(HSYNC_IN) && VSYNC_OUT == !$past(VSYNC_IN))
    else $error("tft syncs not active low");
  crt_pol_a: assert property (@(posedge PCLK) disable iff (!RST_N)
    (CRT_ENABLE && !LCD_ENABLE && !DOUBLE_SCAN) [*8] |->
    HSYNC_OUT == ($past(HSYNC_IN) ^ HSYNC_POL_SEL) &&
    VSYNC_OUT == ($past(VSYNC_IN) ^ VSYNC_POL_SEL)) else $error("crt sync polarity wrong");
endmodule
bind lpo_panel_out lpo_panel_out_chk u_lpo_panel_out_chk (.*);

// ### sim/tb_lpo_panel_out.sv
/*
  Self-checking bench for the LCD panel output stage.
  Assumes the bound checker and the panel model on the panel pins.
*/
`timescale 1ns/1ns
module tb_lpo_panel_out;
  import lpo_pkg::*;
  typedef struct packed {
    logic [5:0] cfg;
    logic [2:0] req;
    logic [7:0] eu;
    logic [7:0] el;
    logic [1:0] eb;
    logic [2:0] ep;
  } lpo_row_t;
  logic CLK = 0, RST_N = 0, PCLK = 0, MEMORY_CLOCK_STOPPED = 0, MEM_WR_EN = 0;
  logic LCD_ENABLE = 0, CRT_ENABLE = 0, PANEL_8BIT = 0, DOUBLE_SCAN = 0, ALT_PIN_MAP = 0;
  logic TWO_SHIFT_CLOCKS = 0, HSYNC_POL_SEL = 0, VSYNC_POL_SEL = 0, PIX_VALID = 0;
  logic BIAS_ON = 0, BACKLIGHT_ON = 0, LOGIC_ON = 0, LINE_END = 0, FRAME_FIRST = 0;
  logic HSYNC_IN = 0, VSYNC_IN = 0, DE_IN = 0, bp;
  lpo_panel_t PANEL_TYPE = LPO_PANEL_MONO;
  logic [7:0] BACKPLANE_RATE = 8'h00, PIX_UPPER = 8'ha5, PIX_LOWER = 8'h3c;
  logic [1:0] PIX_BLUE_LOW = 2'h2, TFT_BLUE_LOW_BITS;
  logic [15:0] strap = 16'ha5c6, MEM_WR_DATA = 16'h3c5a, MEMORY_DATA_LANE_A_OUT, outs;
  logic [15:0] MEMORY_DATA_LANE_A_OE_N, STRAPS, MEMORY_DATA_LANE_A_IN;
  logic [7:0] UPPER_PANEL_DATA, LOWER_PANEL_DATA;
  logic FRAME_START_PULSE, LINE_LATCH_PULSE, PIXEL_SHIFT_CLOCK, SECOND_SHIFT_CLOCK;
  logic BACKPLANE_TOGGLE, PANEL_BIAS_POWER_CTL, BACKLIGHT_POWER_CTL, PANEL_LOGIC_POWER_CTL;
  logic HSYNC_OUT, VSYNC_OUT;
  logic [2:0] cnt = 3'h0;
  int err_count = 0, cmp_count = 0, shifts, shifts2, rows, frames, r0, f0;
  // Rows: {lcd, type, 8bit, alt, two}, power requests, then expected pins.
  lpo_row_t tbl [6] = '{
    {6'h29, 3'h0, 8'ha5, 8'h3c, 2'h0, 3'h4},
    {6'h2c, 3'h7, 8'h05, 8'h0c, 2'h0, 3'h3},
    {6'h30, 3'h5, 8'ha5, 8'h3c, 2'h2, 3'h1},
    {6'h2a, 3'h2, 8'h32, 8'h49, 2'h3, 3'h6},
    {6'h08, 3'h1, 8'h00, 8'h00, 2'h0, 3'h5},
    {6'h24, 3'h6, 8'h05, 8'h0c, 2'h0, 3'h2}
  };
  // Lane A pins read the strap resistors unless the stage drives them.
  assign MEMORY_DATA_LANE_A_IN = (MEMORY_DATA_LANE_A_OE_N & strap) |
                                 (~MEMORY_DATA_LANE_A_OE_N & MEMORY_DATA_LANE_A_OUT);
  assign outs = {8'h00, PANEL_BIAS_POWER_CTL, BACKLIGHT_POWER_CTL, PANEL_LOGIC_POWER_CTL,
                 HSYNC_OUT, VSYNC_OUT, LINE_LATCH_PULSE, BACKPLANE_TOGGLE, FRAME_START_PULSE};
  always #2 CLK = ~CLK;
  always #15 PCLK = ~PCLK;
  always @(posedge PCLK) begin
    #1;
    cnt = cnt + 3'h1;
    {VSYNC_IN, HSYNC_IN, DE_IN} = cnt;
  end
  lpo_panel_out u_lpo_panel_out (.*);
  lpo_panel_model u_lpo_panel_model (
    .xs(PIXEL_SHIFT_CLOCK),
    .xs2(SECOND_SHIFT_CLOCK),
    .lp(LINE_LATCH_PULSE),
    .yd(FRAME_START_PULSE),
    .shifts(shifts),
    .shifts2(shifts2),
    .rows(rows),
    .frames(frames)
  );
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic cclk(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic pclk(input int n);
    repeat (n) @(posedge PCLK);
    #1;
  endtask
  task automatic pix();
    pclk(1);
    PIX_VALID = 1;
    pclk(1);
    PIX_VALID = 0;
    pclk(2);
  endtask
  task automatic line(input logic f);
    pclk(1);
    LINE_END = 1;
    FRAME_FIRST = f;
    pclk(1);
    LINE_END = 0;
    pclk(4);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The whole sequence needs under 10 us; ten times that means a hang.
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    cclk(12);
    RST_N = 1;
    cclk(20);
    chk(STRAPS, 16'ha5c6, "straps");
    strap = 16'h5a39;
    cclk(20);
    chk(STRAPS, 16'ha5c6, "straps held");
    MEM_WR_EN = 1;
    cclk(2);
    chk(MEMORY_DATA_LANE_A_OE_N, 16'h0000, "lane drive");
    chk(MEMORY_DATA_LANE_A_OUT, 16'h3c5a, "lane data");
    MEMORY_CLOCK_STOPPED = 1;
    cclk(8);
    chk(MEMORY_DATA_LANE_A_OE_N, 16'hffff, "lane off");
    MEMORY_CLOCK_STOPPED = 0;
    MEM_WR_EN = 0;
    foreach (tbl[i]) begin
      cclk(1);
      LCD_ENABLE = tbl[i].cfg[5];
      PANEL_TYPE = lpo_panel_t'(tbl[i].cfg[4:3]);
      {PANEL_8BIT, ALT_PIN_MAP, TWO_SHIFT_CLOCKS} = tbl[i].cfg[2:0];
      {BIAS_ON, BACKLIGHT_ON, LOGIC_ON} = tbl[i].req;
      pclk(10);
      pix();
      chk({UPPER_PANEL_DATA, LOWER_PANEL_DATA}, {tbl[i].eu, tbl[i].el}, "data");
      chk({14'h0, TFT_BLUE_LOW_BITS}, {14'h0, tbl[i].eb}, "blue");
      chk({13'h0, outs[7:5]}, {13'h0, tbl[i].ep}, "power");
    end
    chk(16'(shifts), 16'h0005, "shift count");
    chk(16'(shifts2), 16'h0002, "second clock");
    cclk(1);
    PANEL_TYPE = LPO_PANEL_COLOR;
    {BIAS_ON, BACKLIGHT_ON, LOGIC_ON} = 3'h0;
    pclk(10);
    bp = BACKPLANE_TOGGLE;
    r0 = rows;
    f0 = frames;
    line(1'b1);
    line(1'b0);
    line(1'b0);
    chk(16'(rows - r0), 16'h0003, "rows");
    chk(16'(frames - f0), 16'h0001, "frames");
    chk({15'h0, BACKPLANE_TOGGLE}, {15'h0, ~bp}, "backplane");
    // A rate of one toggles the backplane every second line.
    cclk(1);
    BACKPLANE_RATE = 8'h01;
    pclk(10);
    bp = BACKPLANE_TOGGLE;
    line(1'b0);
    chk({15'h0, BACKPLANE_TOGGLE}, {15'h0, bp}, "backplane rate hold");
    line(1'b0);
    chk({15'h0, BACKPLANE_TOGGLE}, {15'h0, ~bp}, "backplane rate");
    cclk(1);
    LCD_ENABLE = 0;
    CRT_ENABLE = 1;
    HSYNC_POL_SEL = 1;
    VSYNC_POL_SEL = 1;
    pclk(20);
    cclk(1);
    DOUBLE_SCAN = 1;
    pclk(20);
    RST_N = 0;
    #1;
    chk(STRAPS, 16'h0000, "reset straps");
    chk(MEMORY_DATA_LANE_A_OE_N, 16'hffff, "reset lane");
    chk(outs, 16'h0000, "reset outputs");
    cclk(12);
    RST_N = 1;
    cclk(20);
    chk(STRAPS, 16'h5a39, "recapture");
    chk({13'h0, outs[7:5]}, 16'h0003, "polarity");
    print_verdict();
  end
endmodule
